/* File: src/ddrp_state.sv */
// Purpose: tracks bank, refresh and power state of a four-bank ddr dram
// Assumes: controller keeps its own timing and ordering duties
// Notes:   outputs expose internal state; no data path is modelled
////////////////////////////////////////////////////////////////////////
// Functional notes
// - read auto-close precharges after half burst
// - delay that precharge until activate-min met
// - write with address bit ten auto-closes
// - write precharge starts recovery after last data
// - refresh is cs ras cas low, cke we high
// - refresh uses own counter, ends all idle
// - self refresh entry encodes cke low refresh
// - self refresh ignores all but clock enable
// - internal clock gated during self refresh
// - cke low idle enters power-down, kind by banks
// - power-down ignores all inputs but cke
// - cke high exits power-down, whatever the command
module ddrp_state
   import ddrp_pkg::*;
#(
   parameter int BURST_LEN = 4  // burst_length_setting
) (
   input  wire logic                 clock,
   input  wire logic                 rst,
   input  wire logic                 cke,        // clock enable pin
   input  wire logic                 csN,
   input  wire logic                 rasN,
   input  wire logic                 casN,
   input  wire logic                 weN,
   input  wire logic [BANK_BITS-1:0] bankAddr,
   input  wire logic [ROW_BITS-1:0]  addr,
   output logic [NUM_BANKS-1:0]      bankOpen,       // row open per bank
   output logic [NUM_BANKS-1:0]      bankPrecharging,// auto or command close
   output logic                      selfRefresh,    // in self refresh
   output logic                      powerDown,      // in power-down
   output logic                      activePowerDown,// power-down with open row
   output logic                      coreClockOn,    // internal clock gate
   output logic [ROW_BITS-1:0]       refreshRow      // internal refresh counter
);
   localparam int HALF_BL = BURST_LEN / 2;
   localparam int PRE_CYC = TRP_CYC;   // precharge length for checks
   ////////////////////////////////////////////////////////////////////
   // state record
   typedef struct packed {
      ddrp_bank_t [NUM_BANKS-1:0]                 bank;
      logic [NUM_BANKS-1:0][CNT_BITS-1:0]         rasCnt; // since activate
      logic [NUM_BANKS-1:0][CNT_BITS-1:0]         apCnt;  // auto-close timer
      ddrp_power_t                                power;
      logic [CNT_BITS-1:0]                        rfCnt;  // refresh timer
      logic                                       ckePrev;
      logic [ROW_BITS-1:0]                        row;
   } ddrp_state_t;

   ddrp_state_t cur, next_cur;  // registered and next state
   logic [3:0]  cmd;            // decoded command code
   logic        allIdle;        // every bank idle
   logic        apHit;          // auto-close flag on column command

   assign cmd   = csN ? CMD_NOP : {1'b0, rasN, casN, weN};
   assign apHit = addr[AUTO_CLOSE_BIT];

   ////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb begin
      next_cur         = cur;
      next_cur.ckePrev = cke;
      allIdle          = 1'b1;
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (cur.bank[b] != BK_IDLE) allIdle = 1'b0;
      end
      // per-bank timers and auto-close sequencing
      for (int b = 0; b < NUM_BANKS; b++) begin
         if (cur.rasCnt[b] != '1) next_cur.rasCnt[b] = cur.rasCnt[b] + 1'b1;
         if (cur.apCnt[b] != '0) next_cur.apCnt[b] = cur.apCnt[b] - 1'b1;
         unique case (cur.bank[b])
            BK_RD_AP, BK_WR_AP: begin
               // start precharge once delay spent and activate_to_precharge_min met
               if (cur.apCnt[b] <= 1 && cur.rasCnt[b] >= ACTIVATE_TO_PRECHARGE_MIN_CYC - 1) begin
                  next_cur.bank[b]  = BK_PRECHARGING;
                  next_cur.apCnt[b] = CNT_BITS'(TRP_CYC);
               end
            end
            BK_PRECHARGING: begin
               if (cur.apCnt[b] <= 1) next_cur.bank[b] = BK_IDLE;
            end
            default: ;
         endcase
      end
      unique case (cur.power)
         PW_RUN: begin
            if (cur.ckePrev && !cke) begin
               // refresh code with cke falling enters self refresh
               if (cmd == CMD_REFRESH && allIdle) next_cur.power = PW_SELFREF;
               else if (cmd == CMD_NOP) next_cur.power = PW_POWERDOWN;
            end else if (cke) begin
               for (int b = 0; b < NUM_BANKS; b++) begin
                  if (bankAddr == BANK_BITS'(b)) begin
                     if (cmd == CMD_ACT && cur.bank[b] == BK_IDLE) begin
                        next_cur.bank[b]   = BK_ACTIVE;
                        next_cur.rasCnt[b] = '0;
                     end else if (cmd == CMD_READ && apHit
                                  && cur.bank[b] == BK_ACTIVE) begin
                        next_cur.bank[b]  = BK_RD_AP;
                        next_cur.apCnt[b] = CNT_BITS'(HALF_BL);
                     end else if (cmd == CMD_WRITE && apHit
                                  && cur.bank[b] == BK_ACTIVE) begin
                        next_cur.bank[b]  = BK_WR_AP;
                        // last data plus write recovery
                        next_cur.apCnt[b] = CNT_BITS'(HALF_BL + 1 + TWR_CYC);
                     end else if (cmd == CMD_PRE && cur.bank[b] == BK_ACTIVE) begin
                        next_cur.bank[b]  = BK_PRECHARGING;
                        next_cur.apCnt[b] = CNT_BITS'(TRP_CYC);
                     end
                  end
               end
               if (cmd == CMD_REFRESH && allIdle) begin
                  next_cur.power = PW_REFRESH;
                  next_cur.rfCnt = CNT_BITS'(REFRESH_CYCLE_TIME_CYC);
                  next_cur.row   = cur.row + 1'b1;
               end
            end
         end
         PW_REFRESH: begin
            if (cur.rfCnt <= 1) next_cur.power = PW_RUN;
            else next_cur.rfCnt = cur.rfCnt - 1'b1;
         end
         PW_POWERDOWN: begin
            // only cke is looked at; exit on cke high
            if (cke) next_cur.power = PW_RUN;
         end
         PW_SELFREF: begin
            if (cke) next_cur.power = PW_RUN;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_cur;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs
   always_comb begin
      for (int b = 0; b < NUM_BANKS; b++) begin
         bankOpen[b]        = cur.bank[b] inside {BK_ACTIVE, BK_RD_AP, BK_WR_AP};
         bankPrecharging[b] = cur.bank[b] == BK_PRECHARGING;
      end
   end
   assign selfRefresh     = cur.power == PW_SELFREF;
   assign powerDown       = cur.power == PW_POWERDOWN;
   assign activePowerDown = powerDown && (|bankOpen);
   assign coreClockOn     = !selfRefresh;
   assign refreshRow      = cur.row;

   ////////////////////////////////////////////////////////////////////
   // checks
   a_refresh_ends_idle: assert property (@(posedge clock) disable iff (rst)
      $fell(cur.power == PW_REFRESH) |-> allIdle)
      else $error("refresh left a bank open");
   a_selfref_clock_off: assert property (@(posedge clock) disable iff (rst)
      selfRefresh |-> !coreClockOn) else $error("clock running in self refresh");
   a_rdap_no_early: assert property (@(posedge clock) disable iff (rst)
      (cur.bank[0] == BK_RD_AP && next_cur.bank[0] == BK_PRECHARGING)
      |-> cur.rasCnt[0] >= ACTIVATE_TO_PRECHARGE_MIN_CYC - 1) else $error("precharge before activate_to_precharge_min");
   a_pd_entry: assert property (@(posedge clock) disable iff (rst)
      (cur.power == PW_RUN && cur.ckePrev && !cke && cmd == CMD_NOP)
      |=> powerDown) else $error("power-down not entered");
   a_pd_exit: assert property (@(posedge clock) disable iff (rst)
      (powerDown && cke) |=> cur.power == PW_RUN) else $error("power-down not left");
   a_sr_entry: assert property (@(posedge clock) disable iff (rst)
      (cur.power == PW_RUN && cur.ckePrev && !cke && cmd == CMD_REFRESH && allIdle)
      |=> selfRefresh) else $error("self refresh not entered");
   a_sr_hold: assert property (@(posedge clock) disable iff (rst)
      (selfRefresh && !cke) |=> selfRefresh) else $error("self refresh left early");
   a_wrap_close: assert property (@(posedge clock) disable iff (rst)
      (cur.power == PW_RUN && cke && cmd == CMD_WRITE && apHit && bankAddr == 2'h0
       && cur.bank[0] == BK_ACTIVE) |=> cur.bank[0] == BK_WR_AP)
      else $error("write auto-close missed");
   // read auto-close of bank 0 starts once both delays are spent
   a_rdap_start: assert property (@(posedge clock) disable iff (rst)
      (cur.bank[0] == BK_RD_AP && cur.apCnt[0] <= 1 && cur.rasCnt[0] >= ACTIVATE_TO_PRECHARGE_MIN_CYC - 1)
      |=> bankPrecharging[0]) else $error("auto-close precharge not started");
   // precharge lasts the precharge period, then idle
   a_pre_length: assert property (@(posedge clock) disable iff (rst)
      $rose(bankPrecharging[0]) |-> ##[PRE_CYC:PRE_CYC] !bankPrecharging[0])
      else $error("precharge length wrong");
   // every auto refresh steps the internal row counter once
   a_refresh_row: assert property (@(posedge clock) disable iff (rst)
      $rose(cur.power == PW_REFRESH) |-> cur.row == $past(cur.row) + 1'b1)
      else $error("refresh row not stepped");
   // power-down held while cke stays low
   a_pd_hold: assert property (@(posedge clock) disable iff (rst)
      (powerDown && !cke) |=> powerDown) else $error("power-down left early");
   // refresh refused while any bank busy
   a_refresh_busy: assert property (@(posedge clock) disable iff (rst)
      (cur.power == PW_RUN && cke && cmd == CMD_REFRESH && !allIdle)
      |=> cur.power == PW_RUN) else $error("refresh taken with bank busy");
endmodule // ddrp_state

/* File: src/ddrp_pkg.sv */
// Purpose: constants for the ddr bank-state and power-state tracker
// Assumes: 200 MHz clock, one command sampled per rising edge
// Notes:   analog minimums are given in ps and turned into cycles here
package ddrp_pkg;
   localparam int CLK_PERIOD_PS    = 5000;  // clock period
   localparam int NUM_BANKS        = 4;     // bank count
   localparam int BANK_BITS        = 2;     // bank address width
   localparam int ROW_BITS         = 13;    // row address width
   localparam int AUTO_CLOSE_BIT   = 10;    // precharge flag address bit
   localparam int ACTIVATE_TO_PRECHARGE_MIN_PS          = 40000; // activate to precharge min
   localparam int TRP_PS           = 15000; // precharge period
   localparam int TWR_PS           = 15000; // write recovery time
   localparam int REFRESH_CYCLE_TIME_PS          = 70000; // refresh cycle time
   // least times round up to whole cycles
   localparam int ACTIVATE_TO_PRECHARGE_MIN_CYC = (ACTIVATE_TO_PRECHARGE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TRP_CYC  = (TRP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TWR_CYC  = (TWR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int REFRESH_CYCLE_TIME_CYC = (REFRESH_CYCLE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_BITS = 8;             // timer width
   // command codes {cs_n, ras_n, cas_n, we_n}; cs_n high is deselect
   localparam logic [3:0] CMD_NOP     = 4'h7;
   localparam logic [3:0] CMD_ACT     = 4'h3;
   localparam logic [3:0] CMD_READ    = 4'h5;
   localparam logic [3:0] CMD_WRITE   = 4'h4;
   localparam logic [3:0] CMD_PRE     = 4'h2;
   localparam logic [3:0] CMD_REFRESH = 4'h1;
   // per-bank phase
   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTIVE, BK_RD_AP, BK_WR_AP, BK_PRECHARGING
   } ddrp_bank_t;
   // device power phase
   typedef enum logic [1:0] {
      PW_RUN, PW_REFRESH, PW_POWERDOWN, PW_SELFREF
   } ddrp_power_t;
endpackage : ddrp_pkg

/* File: test/ddrp_ctrl_model.sv */
// Purpose: controller-side pin driver for the ddr state tracker
// Assumes: the bench keeps command spacing and order
// Notes:   pins move on falling edges; idle address lines wander
module ddrp_ctrl_model
   import ddrp_pkg::*;
(
   input  wire logic                 clock,
   input  wire logic [4:0]           req,     // {cke, cs, ras, cas, we}
   input  wire logic [BANK_BITS-1:0] reqBank,
   input  wire logic [ROW_BITS-1:0]  reqAddr,
   output logic                      cke,
   output logic                      csN,
   output logic                      rasN,
   output logic                      casN,
   output logic                      weN,
   output logic [BANK_BITS-1:0]      bankAddr,
   output logic [ROW_BITS-1:0]       addr
);
   timeunit 1ns;
   timeprecision 1ps;
   // deselected with clock enable high until the first request
   initial {cke, csN, rasN, casN, weN, bankAddr, addr} = '1;
   // half a cycle of setup before the sampling edge
   always @(negedge clock) begin
      {cke, csN, rasN, casN, weN} <= req;
      bankAddr <= reqBank;
      addr <= req[3] ? ~addr : reqAddr;
   end
endmodule // ddrp_ctrl_model

/* File: test/tb_ddr_autoprecharge_refresh_powerdown.sv */
// Purpose: self-checking bench for the ddr state tracker
// Assumes: commands are taken one per rising edge
// Notes:   every change of the twelve-bit state output vector is matched in order against a queue
module tb_ddr_autoprecharge_refresh_powerdown
   import ddrp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BL = 4;
   logic                 clock = 1'b0;
   logic                 rst   = 1'b1;
   logic                 ck    = 1'b1;   // clock enable to apply
   logic [4:0]           req   = 5'h1f;
   logic [BANK_BITS-1:0] reqBank = '0;
   logic [ROW_BITS-1:0]  reqAddr = '0;
   logic [11:0]          expQ[$];
   logic [11:0]          last = 12'h001;
   int n_errors = 0, check_count = 0, cyc = 0;
   int unsigned seed = 50;
   wire cke, csN, rasN, casN, weN, selfRefresh, powerDown, activePowerDown, coreClockOn;
   wire [BANK_BITS-1:0] bankAddr;
   wire [ROW_BITS-1:0]  addr, refreshRow;
   wire [NUM_BANKS-1:0] bankOpen, bankPrecharging;
   wire [11:0] vec = {bankOpen, bankPrecharging, selfRefresh, powerDown,
                      activePowerDown, coreClockOn};
   ddrp_ctrl_model ctrl (.clock(clock), .req(req), .reqBank(reqBank),
      .reqAddr(reqAddr), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
      .weN(weN), .bankAddr(bankAddr), .addr(addr));
   ddrp_state #(.BURST_LEN(BL)) DUT (.clock(clock), .rst(rst),
      .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
      .bankAddr(bankAddr), .addr(addr), .bankOpen(bankOpen),
      .bankPrecharging(bankPrecharging), .selfRefresh(selfRefresh),
      .powerDown(powerDown), .activePowerDown(activePowerDown),
      .coreClockOn(coreClockOn), .refreshRow(refreshRow));
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [12:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[12:0];
   endfunction
   task automatic bad(input string m);
      n_errors++;
      $display("BAD %0t %s", $time, m);
   endtask
   // one command, taken at the next rising edge
   task automatic put(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
      req = {ck, c};
      reqBank = b;
      reqAddr = a;
      @(negedge clock);
      @(posedge clock);
   endtask
   task automatic idle(input int n);
      repeat (n) put(CMD_NOP, 2'h0, rnd());
   endtask
   // cycles until a bank starts its automatic close
   task automatic waitPre(input int b, input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (n < 20 && bankPrecharging[b] !== 1'b1) begin
         idle(1);
         #1;
         n++;
      end
      check_count++;
      if (n < lo || n > hi) bad("auto close start out of window");
   endtask
   task automatic tally_and_finish();
      if (expQ.size() != 0) bad("expected change never seen");
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial forever #2.5 clock = ~clock;
   // cycle ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 1500) bad("timeout");
      if (cyc == 1500) tally_and_finish();
   end
   // each change of the state outputs takes the oldest note
   always @(negedge clock) begin
      if (!rst && vec !== last) begin
         last = vec;
         check_count++;
         if (expQ.size() == 0) bad("unexpected state change");
         else if (expQ.pop_front() !== vec) bad("state mismatch");
      end
   end
   initial begin
      repeat (8) @(negedge clock);
      rst = 1'b0;
      @(posedge clock);
      idle(2);
      expQ = {12'h101, 12'h011, 12'h001, 12'h101, 12'h011, 12'h001};
      put(CMD_ACT, 2'h0, rnd());
      put(CMD_READ, 2'h0, rnd() | 13'h0400);
      waitPre(0, ACTIVATE_TO_PRECHARGE_MIN_CYC - 2, ACTIVATE_TO_PRECHARGE_MIN_CYC);
      idle(6);
      put(CMD_ACT, 2'h0, rnd());
      idle(ACTIVATE_TO_PRECHARGE_MIN_CYC + 2);
      put(CMD_READ, 2'h0, rnd() | 13'h0400);
      waitPre(0, BL / 2 - 1, BL / 2 + 1);
      idle(6);
      expQ = {12'h201, 12'h601, 12'h421, 12'h401, 12'h041, 12'h001};
      put(CMD_ACT, 2'h1, rnd());
      put(CMD_ACT, 2'h2, rnd());
      idle(ACTIVATE_TO_PRECHARGE_MIN_CYC);
      put(CMD_WRITE, 2'h1, rnd() | 13'h0400);
      put(CMD_WRITE, 2'h2, rnd() & 13'h1bff);
      waitPre(1, BL / 2 + TWR_CYC - 1, BL / 2 + TWR_CYC + 1);
      idle(6);
      put(CMD_PRE, 2'h2, rnd() & 13'h1bff);
      idle(6);
      repeat (2) begin
         put(CMD_REFRESH, 2'(rnd()), rnd());
         idle(REFRESH_CYCLE_TIME_CYC);
      end
      check_count++;
      if (refreshRow !== 13'h0002) bad("refresh counter");
      expQ = {12'h801, 12'h807, 12'h801, 12'h081, 12'h001, 12'h005, 12'h001};
      put(CMD_ACT, 2'h3, rnd());
      idle(ACTIVATE_TO_PRECHARGE_MIN_CYC);
      ck = 1'b0;
      idle(1);
      repeat (4) put(4'(rnd()), 2'(rnd()), rnd());
      ck = 1'b1;
      idle(2);
      put(CMD_PRE, 2'h3, rnd() & 13'h1bff);
      idle(5);
      ck = 1'b0;
      idle(3);
      ck = 1'b1;
      idle(2);
      expQ = {12'h008, 12'h001};
      ck = 1'b0;
      put(CMD_REFRESH, 2'h0, rnd());
      repeat (4) put(CMD_ACT, 2'(rnd()), rnd());
      ck = 1'b1;
      idle(200);
      reqAddr = refreshRow;
      put(CMD_REFRESH, 2'h1, rnd());
      idle(REFRESH_CYCLE_TIME_CYC + 1);
      check_count++;
      if (refreshRow !== 13'h0003) bad("refresh after exit");
      tally_and_finish();
   end
endmodule // tb_ddr_autoprecharge_refresh_powerdown
